// [core/mcsb_regs.svh]
// Register offsets, field positions, reset values and timing counts of the monitor bank
`ifndef MCSB_REGS_SVH
`define MCSB_REGS_SVH
`define MCSB_IDX_CONFIG 8'h40
`define MCSB_IDX_STATUS1 8'h41
`define MCSB_IDX_STATUS2 8'h42
`define MCSB_IDX_IRQ_MASK 8'h43
`define MCSB_IDX_RAIL_LO 8'h44
`define MCSB_IDX_RAIL_HI 8'h45
`define MCSB_IDX_VCC_LO 8'h48
`define MCSB_IDX_VCC_HI 8'h49
`define MCSB_IDX_R1_LO 8'h4e
`define MCSB_IDX_R1_HI 8'h4f
`define MCSB_IDX_LT_LO 8'h50
`define MCSB_IDX_LT_HI 8'h51
`define MCSB_IDX_R2_LO 8'h52
`define MCSB_IDX_R2_HI 8'h53
`define MCSB_CFG_RESET 8'h00
`define MCSB_CFG_GO 0
`define MCSB_CFG_LOCK 1
`define MCSB_CFG_READY 2
`define MCSB_CFG_FULL 3
`define MCSB_CFG_UNUSED 4
`define MCSB_CFG_SPINDIS 5
`define MCSB_CFG_BUS_TIMEOUT_DISABLE 6
`define MCSB_CFG_VCC5 7
`define MCSB_CFG_WMASK_LOCKED 8'h08
`define MCSB_CFG_WMASK_OPEN 8'he9
`define MCSB_ST_RAIL 0
`define MCSB_ST_VCC 2
`define MCSB_ST_R1 4
`define MCSB_ST_LT 5
`define MCSB_ST_R2 6
`define MCSB_ST_SUM 7
`define MCSB_ST_ALARM_MASK 8'h75
`define MCSB_VOLT_LO_RST 8'h00
`define MCSB_VOLT_HI_RST 8'hff
`define MCSB_TEMP_LO_RST 8'h81
`define MCSB_TEMP_HI_RST 8'h7f
`define MCSB_POWERUP_NS 1000
`define MCSB_CLK_NS 40
`define MCSB_POWERUP_CYC ((`MCSB_POWERUP_NS + `MCSB_CLK_NS - 1) / `MCSB_CLK_NS)
`endif

// [core/mcsb_pkg.sv]
// Types shared by the monitor configuration and status bank
package mcsb_pkg;
  typedef struct packed {
    logic [7:0] rail_2v5;
    logic [7:0] vcc;
    logic [7:0] remote1;
    logic [7:0] local_t;
    logic [7:0] remote2;
  } mcsb_readings_s;
  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
  } mcsb_limit_s;
  typedef enum logic [1:0] {
    MCSB_IDLE = 2'b00,
    MCSB_ANSWER = 2'b01
  } mcsb_bus_e;
endpackage

// [core/mcsb_bank.sv]
// Monitor configuration and first alarm status register bank with Avalon-MM slave
`timescale 1ns/100ps
`include "mcsb_regs.svh"
module mcsb_bank
  import mcsb_pkg::*;
#(
  parameter int POWERUP_CYC = `MCSB_POWERUP_CYC
) (
  input wire logic ref_clk, // 25 MHz clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [7:0] avs_address, // Word index
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data, low byte used
  input wire logic [3:0] avs_byteenable, // Byte enables
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall until answer
  output logic avs_response_err, // Unmapped address answer
  input wire mcsb_readings_s readings, // Measured values, same clock
  input wire logic [7:0] status2_bits, // Second status register bits
  output logic [7:0] status2_read_clr, // Clear pulse for second status bits
  output mcsb_readings_s lim_sel_lo, // Active low limits
  output mcsb_readings_s lim_sel_hi, // Active high limits
  output logic monitor_go, // Monitoring enabled
  output logic fans_full_speed, // Force all fans to full
  output logic spinup_pulse_disable, // Hold PWM full spin-up timeout
  output logic bus_timeout_disable, // Disable bus timeout detection
  output logic vcc_5v_scale, // Supply scaled for 5 V
  output logic irq // Level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // Register map, by word index
  // 0x40 monitor_configuration: go, lock, ready, full speed, spin-up, timeout, scale
  // 0x41 alarm_status_first: sticky alarms, read clears, bit 7 live summary
  // 0x42 second status register: held outside, a read pulses its clear
  // 0x43 interrupt mask: same layout as the first status register
  // 0x44 and 0x45: 2.5 V rail low and high limits
  // 0x48 and 0x49: supply low and high limits
  // 0x4e and 0x4f: remote channel 1 low and high limits
  // 0x50 and 0x51: local sensor low and high limits
  // 0x52 and 0x53: remote channel 2 low and high limits
  // Any other index answers with the error response, reads zero, drops writes
  // Limits stay writable under lock; only the configuration bits freeze
  // Byte enable bit 0 must be high for a write to land anywhere
  // Known limits of this block:
  // The second status register lives outside and owns its set logic
  // Readings are taken as same-clock values, with no filtering
  // Temperatures are two's complement codes; voltages are plain unsigned
  // A mask write reaches the interrupt one cycle later
  // The interrupt drops once its status bits clear (a read of 0x41, or of 0x42 for the summary) or a mask write hides them
  // Only the low byte lane is decoded; upper lanes are dropped

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Out of limit: strictly above high, or at or below low
  function automatic logic out_of_limit(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    out_of_limit = (v > hi) || (v <= lo);
  endfunction

  // Temperature codes are two's complement, so their compare is signed
  function automatic logic temp_out_of_limit(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    temp_out_of_limit = ($signed(v) > $signed(hi)) || ($signed(v) <= $signed(lo));
  endfunction

  // Byte lane 0 carries the register; other lanes are ignored
  function automatic logic [7:0] merge_be(input logic [7:0] old_v, input logic [31:0] wd, input logic [3:0] be);
    merge_be = be[0] ? wd[7:0] : old_v;
  endfunction

  // Bus state and stored registers
  mcsb_bus_e state;
  logic [7:0] cfg;
  logic [7:0] status1;
  logic [7:0] irq_mask;
  logic ready;
  logic [15:0] pu_cnt;
  logic [7:0] next_cfg;
  logic [7:0] next_status1;
  logic cfg_wr;

  // Limit sets: programmed, power-up defaults and the set in use
  mcsb_readings_s prog_lo;
  mcsb_readings_s prog_hi;
  mcsb_readings_s def_lo;
  mcsb_readings_s def_hi;
  mcsb_readings_s act_lo;
  mcsb_readings_s act_hi;

  // Alarm conditions, status view and bus decode
  logic [7:0] cond;
  logic [7:0] status_view;
  logic take;
  logic wr_hit;
  logic rd_hit;
  logic mapped;
  logic [7:0] rd_byte;
  logic [7:0] wmask;

  // Taken only in idle, so the answer cycle never takes the same request twice
  assign take = (state == MCSB_IDLE) && (avs_read || avs_write);
  assign wr_hit = take && avs_write;
  assign rd_hit = take && avs_read;

  ////////////////////////////////////////////////////////////////////////////
  // Power-up readiness counter

  // Ready only after internal settling; counts once after reset release
  // Counter stops once ready, so it cannot wrap and drop the flag again
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pu_cnt <= 16'h0000;
      ready <= 1'b0;
    end else if (!ready) begin
      if (pu_cnt == 16'(POWERUP_CYC - 1)) begin
        ready <= 1'b1;
      end
      pu_cnt <= pu_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register

  // Lock freezes go, lock itself, spin-up, timeout and scaling; full speed stays writable
  // Spin-up disable is treated as lockable, since nothing marks it otherwise
  assign wmask = cfg[`MCSB_CFG_LOCK] ? `MCSB_CFG_WMASK_LOCKED : `MCSB_CFG_WMASK_OPEN;

  // Only a taken write with lane 0 enabled reaches the configuration byte
  assign cfg_wr = wr_hit && (avs_address == `MCSB_IDX_CONFIG) && avs_byteenable[0];

  // Masked merge; the lock bit can only be raised, never cleared short of reset
  // Ready and the reserved bit are kept low in storage; the read side fills them
  always_comb begin
    next_cfg = (cfg & ~wmask) | (avs_writedata[7:0] & wmask);
    next_cfg[`MCSB_CFG_LOCK] = cfg[`MCSB_CFG_LOCK] | avs_writedata[`MCSB_CFG_LOCK];
    next_cfg[`MCSB_CFG_READY] = 1'b0;
    next_cfg[`MCSB_CFG_UNUSED] = 1'b0;
  end

  // Stored byte changes only on such a write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= `MCSB_CFG_RESET;
    end else if (cfg_wr) begin
      cfg <= next_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limit registers, not lockable
  // Each index holds one byte; the lock never reaches these

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prog_lo <= {`MCSB_VOLT_LO_RST, `MCSB_VOLT_LO_RST, `MCSB_TEMP_LO_RST, `MCSB_TEMP_LO_RST, `MCSB_TEMP_LO_RST};
      prog_hi <= {`MCSB_VOLT_HI_RST, `MCSB_VOLT_HI_RST, `MCSB_TEMP_HI_RST, `MCSB_TEMP_HI_RST, `MCSB_TEMP_HI_RST};
    end else if (wr_hit) begin
      if (avs_address == `MCSB_IDX_RAIL_LO) begin
        prog_lo.rail_2v5 <= merge_be(prog_lo.rail_2v5, avs_writedata, avs_byteenable);
      end else if (avs_address == `MCSB_IDX_RAIL_HI) begin
        prog_hi.rail_2v5 <= merge_be(prog_hi.rail_2v5, avs_writedata, avs_byteenable);
      end else if (avs_address == `MCSB_IDX_VCC_LO) begin
        prog_lo.vcc <= merge_be(prog_lo.vcc, avs_writedata, avs_byteenable);
      end else if (avs_address == `MCSB_IDX_VCC_HI) begin
        prog_hi.vcc <= merge_be(prog_hi.vcc, avs_writedata, avs_byteenable);
      end else if (avs_address == `MCSB_IDX_R1_LO) begin
        prog_lo.remote1 <= merge_be(prog_lo.remote1, avs_writedata, avs_byteenable);
      end else if (avs_address == `MCSB_IDX_R1_HI) begin
        prog_hi.remote1 <= merge_be(prog_hi.remote1, avs_writedata, avs_byteenable);
      end else if (avs_address == `MCSB_IDX_LT_LO) begin
        prog_lo.local_t <= merge_be(prog_lo.local_t, avs_writedata, avs_byteenable);
      end else if (avs_address == `MCSB_IDX_LT_HI) begin
        prog_hi.local_t <= merge_be(prog_hi.local_t, avs_writedata, avs_byteenable);
      end else if (avs_address == `MCSB_IDX_R2_LO) begin
        prog_lo.remote2 <= merge_be(prog_lo.remote2, avs_writedata, avs_byteenable);
      end else if (avs_address == `MCSB_IDX_R2_HI) begin
        prog_hi.remote2 <= merge_be(prog_hi.remote2, avs_writedata, avs_byteenable);
      end
    end
  end

  // Defaults apply while go is low; programmed values are kept meanwhile
  assign def_lo = {`MCSB_VOLT_LO_RST, `MCSB_VOLT_LO_RST, `MCSB_TEMP_LO_RST, `MCSB_TEMP_LO_RST, `MCSB_TEMP_LO_RST};
  assign def_hi = {`MCSB_VOLT_HI_RST, `MCSB_VOLT_HI_RST, `MCSB_TEMP_HI_RST, `MCSB_TEMP_HI_RST, `MCSB_TEMP_HI_RST};
  assign act_lo = cfg[`MCSB_CFG_GO] ? prog_lo : def_lo;
  assign act_hi = cfg[`MCSB_CFG_GO] ? prog_hi : def_hi;

  ////////////////////////////////////////////////////////////////////////////
  // Alarm conditions

  // Voltages compare unsigned, temperatures signed, against the limit set in use
  // Signed temperatures keep the default limits quiet for every reading except 0x80 and 0x81
  // Bits 1, 3 and 7 stay zero here; the summary is added on the read side
  always_comb begin
    cond = 8'h00;
    cond[`MCSB_ST_RAIL] = out_of_limit(readings.rail_2v5, act_lo.rail_2v5, act_hi.rail_2v5);
    cond[`MCSB_ST_VCC] = out_of_limit(readings.vcc, act_lo.vcc, act_hi.vcc);
    cond[`MCSB_ST_R1] = temp_out_of_limit(readings.remote1, act_lo.remote1, act_hi.remote1);
    cond[`MCSB_ST_LT] = temp_out_of_limit(readings.local_t, act_lo.local_t, act_hi.local_t);
    cond[`MCSB_ST_R2] = temp_out_of_limit(readings.remote2, act_lo.remote2, act_hi.remote2);
  end

  ////////////////////////////////////////////////////////////////////////////
  // First status register

  // Set wins over the read clear; a read clears only bits whose cause has gone
  // Writes never reach this byte, so software cannot fake or hide an alarm
  always_comb begin
    next_status1 = status1 | cond;
    if (rd_hit && avs_address == `MCSB_IDX_STATUS1) begin
      next_status1 = cond;
    end
    next_status1 = next_status1 & `MCSB_ST_ALARM_MASK;
  end

  // No write path at all
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      status1 <= 8'h00;
    end else begin
      status1 <= next_status1;
    end
  end

  // Summary follows the second register live
  // Not latched: clearing the second register clears the summary at once
  assign status_view = {(|status2_bits), status1[6:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt mask

  // Mask bits line up with the status bits they gate, summary included
  // Reset leaves every source masked, so the pin starts low
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask <= 8'h00;
    end else if (wr_hit && avs_address == `MCSB_IDX_IRQ_MASK) begin
      irq_mask <= merge_be(irq_mask, avs_writedata, avs_byteenable);
    end
  end

  // Registered so the pin never glitches while the decode settles
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_view & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode

  // Unmapped indices read zero and raise the error with the answer
  // Ready and the reserved bit come from the counter and a constant, not storage
  always_comb begin
    mapped = 1'b1;
    rd_byte = 8'h00;
    if (avs_address == `MCSB_IDX_CONFIG) begin
      rd_byte = {cfg[7:5], 1'b0, cfg[3], ready, cfg[1:0]};
    end else if (avs_address == `MCSB_IDX_STATUS1) begin
      rd_byte = status_view;
    end else if (avs_address == `MCSB_IDX_STATUS2) begin
      rd_byte = status2_bits;
    end else if (avs_address == `MCSB_IDX_IRQ_MASK) begin
      rd_byte = irq_mask;
    end else if (avs_address == `MCSB_IDX_RAIL_LO) begin
      rd_byte = prog_lo.rail_2v5;
    end else if (avs_address == `MCSB_IDX_RAIL_HI) begin
      rd_byte = prog_hi.rail_2v5;
    end else if (avs_address == `MCSB_IDX_VCC_LO) begin
      rd_byte = prog_lo.vcc;
    end else if (avs_address == `MCSB_IDX_VCC_HI) begin
      rd_byte = prog_hi.vcc;
    end else if (avs_address == `MCSB_IDX_R1_LO) begin
      rd_byte = prog_lo.remote1;
    end else if (avs_address == `MCSB_IDX_R1_HI) begin
      rd_byte = prog_hi.remote1;
    end else if (avs_address == `MCSB_IDX_LT_LO) begin
      rd_byte = prog_lo.local_t;
    end else if (avs_address == `MCSB_IDX_LT_HI) begin
      rd_byte = prog_hi.local_t;
    end else if (avs_address == `MCSB_IDX_R2_LO) begin
      rd_byte = prog_lo.remote2;
    end else if (avs_address == `MCSB_IDX_R2_HI) begin
      rd_byte = prog_hi.remote2;
    end else begin
      mapped = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: take in idle, answer one cycle later with waitrequest low
  // Each transfer costs at least two cycles: the idle cycle that takes, then the answer

  // Side effects land at the taking edge; the answer trails by one cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= MCSB_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      avs_response_err <= 1'b0;
      status2_read_clr <= 8'h00;
    end else begin
      status2_read_clr <= 8'h00;
      case (state)
        MCSB_IDLE: begin
          avs_waitrequest <= 1'b1;
          if (take) begin
            state <= MCSB_ANSWER;
            avs_waitrequest <= 1'b0;
            avs_response_err <= !mapped;
            avs_readdata <= avs_read ? {24'h000000, rd_byte} : 32'h00000000;
            if (avs_read && avs_address == `MCSB_IDX_STATUS2) begin
              status2_read_clr <= 8'hff;
            end
          end
        end
        MCSB_ANSWER: begin
          // Request is still up here; going idle first keeps it from a second take
          state <= MCSB_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          state <= MCSB_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs

  // Levels trail the stored bits by one cycle; limit sets travel as whole structs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      monitor_go <= 1'b0;
      fans_full_speed <= 1'b0;
      spinup_pulse_disable <= 1'b0;
      bus_timeout_disable <= 1'b0;
      vcc_5v_scale <= 1'b0;
      lim_sel_lo <= '0;
      lim_sel_hi <= '0;
    end else begin
      monitor_go <= cfg[`MCSB_CFG_GO];
      fans_full_speed <= cfg[`MCSB_CFG_FULL];
      spinup_pulse_disable <= cfg[`MCSB_CFG_SPINDIS];
      bus_timeout_disable <= cfg[`MCSB_CFG_BUS_TIMEOUT_DISABLE];
      vcc_5v_scale <= cfg[`MCSB_CFG_VCC5];
      lim_sel_lo <= act_lo;
      lim_sel_hi <= act_hi;
    end
  end

endmodule // mcsb_bank

// [bench/mcsb_far_model.sv]
// Far-side model: sensor readings and second status register contents
`timescale 1ns/100ps
module mcsb_far_model
  import mcsb_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Reset, active low
  input wire mcsb_readings_s next_readings, // Values to measure
  input wire logic [7:0] s2_event, // One-cycle events
  input wire logic [7:0] status2_read_clr, // Clear pulse from bank
  output mcsb_readings_s readings, // Measured values
  output logic [7:0] status2_bits // Second status flags
);
  ////////////////////////////////////////////////////////////////////////////
  // Readings update once a clock; flags stick until the bank's read pulse
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      readings <= '0;
      status2_bits <= 8'h00;
    end else begin
      readings <= next_readings;
      status2_bits <= (status2_bits & ~status2_read_clr) | s2_event;
    end
  end
endmodule // mcsb_far_model

// [bench/mcsb_bank_sva.sv]
// Assertion checker bound to the monitor bank ports
`timescale 1ns/100ps
module mcsb_bank_chk
  import mcsb_pkg::*;
#(
  parameter int POWERUP_CYC = 25
) (
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Reset
  input wire logic [7:0] avs_address, // Index
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_writedata, // Wdata
  input wire logic [3:0] avs_byteenable, // Enables
  input wire logic [31:0] avs_readdata, // Rdata
  input wire logic avs_waitrequest, // Stall
  input wire logic avs_response_err, // Error
  input wire logic [7:0] status2_bits, // Status 2
  input wire mcsb_readings_s lim_sel_lo, // Low limits
  input wire logic monitor_go, // Go
  input wire logic fans_full_speed, // Full speed
  input wire logic spinup_pulse_disable, // Spin-up
  input wire logic bus_timeout_disable, // Timeout off
  input wire logic vcc_5v_scale // Supply scale
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic done_rd;
  logic done_wr;
  logic lk1;
  logic lk2;
  logic [1:0] warm;
  assign done_rd = avs_read && !avs_waitrequest;
  assign done_wr = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == 8'h40;
  ////////////////////////////////////////////////////////////////////////////
  // Lock seen on the bus, delayed twice because outputs trail the register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lk1 <= 1'b0;
      lk2 <= 1'b0;
      warm <= 2'd0;
    end else begin
      lk1 <= lk1 | (done_wr & avs_writedata[1]);
      lk2 <= lk1;
      warm <= (warm == 2'd3) ? warm : warm + 2'd1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_wait_stand; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_stand: assert property (p_wait_stand) else $error("answer longer than one cycle");
  property p_answer; (avs_read || avs_write) && avs_waitrequest |-> ##[1:3] !avs_waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_unmapped; done_rd && avs_address < 8'h40 |-> avs_response_err && avs_readdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not flagged");
  property p_st_res; done_rd && avs_address == 8'h41 |-> avs_readdata[3] == 1'b0 && avs_readdata[1] == 1'b0;
  endproperty
  a_st_res: assert property (p_st_res) else $error("status reserved bit set");
  property p_cfg_res; done_rd && avs_address == 8'h40 |-> avs_readdata[4] == 1'b0; endproperty
  a_cfg_res: assert property (p_cfg_res) else $error("config reserved bit set");
  property p_summary; done_rd && avs_address == 8'h41 |-> avs_readdata[7] == |$past(status2_bits); endproperty
  a_summary: assert property (p_summary) else $error("summary bit wrong");
  property p_full; done_wr |=> fans_full_speed == $past(avs_writedata[3]); endproperty
  a_full: assert property (p_full) else $error("full speed not written");
  property p_lock; lk2 |-> $stable({monitor_go, spinup_pulse_disable, bus_timeout_disable, vcc_5v_scale});
  endproperty
  a_lock: assert property (p_lock) else $error("locked bit changed");
  property p_defaults; warm == 2'd3 && !monitor_go && !$past(monitor_go) |->
    lim_sel_lo == {8'h00, 8'h00, 8'h81, 8'h81, 8'h81}; endproperty
  a_defaults: assert property (p_defaults) else $error("default limits not used");
endmodule // mcsb_bank_chk
bind mcsb_bank mcsb_bank_chk #(.POWERUP_CYC(POWERUP_CYC)) chk_i (.ref_clk, .arst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response_err,
  .status2_bits, .lim_sel_lo, .monitor_go, .fans_full_speed, .spinup_pulse_disable, .bus_timeout_disable,
  .vcc_5v_scale);

// [bench/monitor_config_and_status_bank_test.sv]
// Testbench for the monitor configuration and status bank
`timescale 1ns/100ps
module monitor_config_and_status_bank_test
  import mcsb_pkg::*;
;
  localparam int PU = 25;
  logic ref_clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, e;
  logic [7:0] avs_address = 8'h00, s2_event = 8'h00, status2_bits, status2_read_clr;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'h1;
  logic avs_waitrequest, avs_response_err, monitor_go, fans_full_speed, spinup_pulse_disable;
  logic bus_timeout_disable, vcc_5v_scale, irq;
  mcsb_readings_s nr = {8'h40, 8'h40, 8'h10, 8'h10, 8'h10}, readings, lim_sel_hi;
  int bad_count = 0, n_checks = 0;
  mcsb_bank #(.POWERUP_CYC(PU)) uut (.ref_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response_err, .readings, .status2_bits,
    .status2_read_clr, .lim_sel_lo(), .lim_sel_hi, .monitor_go, .fans_full_speed, .spinup_pulse_disable,
    .bus_timeout_disable, .vcc_5v_scale, .irq);
  mcsb_far_model far (.ref_clk, .arst_n, .next_readings(nr), .s2_event, .status2_read_clr, .readings,
    .status2_bits);
  ////////////////////////////////////////////////////////////////////////////
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // One bus transfer; the request is held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    e = avs_response_err;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin
      bad_count++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(q, exp);
  endtask
  // Lets a reading pass the far register and the bank's latch
  task automatic settle;
    repeat (4) @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(8'h40, 32'h00);
    repeat (PU + 5) @(posedge ref_clk);
    rd(8'h40, 32'h04);
    wr(8'h45, 8'h80);
    for (int k = 0; k < 3; k++) wr(8'h4e + 8'(2 * k), 8'h05);
    wr(8'h40, 8'he1);
    rd(8'h40, 32'he5);
    chk({monitor_go, spinup_pulse_disable, bus_timeout_disable, vcc_5v_scale}, 32'hf);
    chk(lim_sel_hi.rail_2v5, 32'h80);
    bus(1'b0, 8'h41, 8'h00);
    chk(q, 32'h05);
    rd(8'h41, 32'h00);
    // Equal to the high limit is not an alarm, one above is
    nr.rail_2v5 <= 8'h80;
    settle();
    rd(8'h41, 32'h00);
    nr.rail_2v5 <= 8'h81;
    settle();
    nr.rail_2v5 <= 8'h40;
    settle();
    rd(8'h41, 32'h01);
    rd(8'h41, 32'h00);
    // A condition still present survives the read
    nr.vcc <= 8'h00;
    settle();
    rd(8'h41, 32'h04);
    rd(8'h41, 32'h04);
    nr.vcc <= 8'h40;
    settle();
    rd(8'h41, 32'h04);
    rd(8'h41, 32'h00);
    for (int k = 0; k < 3; k++) begin
      nr[23 - 8 * k -: 8] <= (k == 1) ? 8'h80 : 8'h05;
      settle();
      nr[23 - 8 * k -: 8] <= 8'h10;
      settle();
      rd(8'h41, 32'h10 << k);
    end
    // Masked local source stays quiet; unmasked rail source raises the interrupt, cleared by the read
    wr(8'h43, 8'h01);
    nr.local_t <= 8'h05;
    settle();
    nr.local_t <= 8'h10;
    settle();
    chk(irq, 32'h0);
    rd(8'h41, 32'h20);
    nr.rail_2v5 <= 8'h81;
    settle();
    nr.rail_2v5 <= 8'h40;
    settle();
    chk(irq, 32'h1);
    rd(8'h41, 32'h01);
    settle();
    chk(irq, 32'h0);
    // Second register event seen through the summary bit
    s2_event <= 8'h10;
    settle();
    s2_event <= 8'h00;
    rd(8'h41, 32'h80);
    rd(8'h42, 32'h10);
    settle();
    rd(8'h41, 32'h00);
    wr(8'h41, 8'hff);
    rd(8'h41, 32'h00);
    bus(1'b0, 8'h20, 8'h00);
    chk({31'h0, e}, 32'h1);
    avs_byteenable <= 4'h0;
    wr(8'h40, 8'h08);
    avs_byteenable <= 4'h1;
    rd(8'h40, 32'he5);
    // Lock, then try to change everything
    wr(8'h40, 8'h0a);
    rd(8'h40, 32'h0e);
    wr(8'h40, 8'hf5);
    rd(8'h40, 32'h06);
    chk({monitor_go, spinup_pulse_disable, bus_timeout_disable, vcc_5v_scale, fans_full_speed}, 32'h0);
    chk(lim_sel_hi.rail_2v5, 32'hff);
    rd(8'h45, 32'h80);
    wrap_up();
  end
endmodule // monitor_config_and_status_bank_test
